// ### core/csf_comparator_status.sv
// Control and status logic around three clocked comparators.
// Assumes analog comparator cores and a conversion trigger consumer outside;
// comparator results and pin levels arrive asynchronously.
//
// Overview of operation
// - 3-bit select routes comparator 2 negative input; 110 and 111 reserved.
// - Clock-halve bit 7 set runs comparators at half the system clock.
// - Event flags in bits 6,5,4 set on the selected output transition.
// - Vector execution clears a flag only while its interrupt enable is set.
// - Writing one to a flag position clears that flag.
// - Each event flag is offered as an ADC and DAC conversion trigger.
// - Status bits 2,1,0 read back comparator outputs 2,1,0.
// - First disable register bits 3:2 turn off negative and cmp2 pin inputs.
// - Second disable register bits 5 and 2 turn off cmp0 and cmp1 pins.
// - Sensitivity 00 toggle, 01 reserved, 10 falling, 11 rising.
// - Results sampled on comparator clock falling edge, full or half rate.
// - Interrupt requested only while enable and event flag are both one.
`timescale 1ns/1ps

module csf_comparator_status
	import csf_pkg::*;
#(
	parameter int NUM_CMP = 3
)
(
	// Clock, reset, enable
	input  wire logic                core_clk,
	input  wire logic                rstn,
	input  wire logic                clk_en,
	// Avalon-MM slave
	input  wire logic [4:0]          avs_address,
	input  wire logic                avs_read,
	input  wire logic                avs_write,
	input  wire logic [31:0]         avs_writedata,
	input  wire logic [3:0]          avs_byteenable,
	output logic      [31:0]         avs_readdata,
	output logic                     avs_waitrequest,
	// Comparator cores
	input  wire logic [NUM_CMP-1:0]  cmp_result,
	output logic [NUM_CMP-1:0]       cmp_enable,
	output logic [2:0]               cmp2_neg_select,
	output logic                     cmp_sample_strobe,
	// Interrupts and conversion triggers
	input  wire logic [NUM_CMP-1:0]  irq_vector_taken,
	output logic [NUM_CMP-1:0]       irq_request,
	output logic [NUM_CMP-1:0]       conv_trigger,
	// Analog pins with digital input buffers
	input  wire csf_pins_t           pin_level,
	output csf_pins_t                pin_buffer_off,
	output csf_pins_t                pin_read
);

	// ****************************************
	// Functions
	// ****************************************

	// Edge match for one comparator; the reserved code never fires
	function automatic logic edge_hit(input csf_sens_t sens,
		input logic cur, input logic prev);
		logic hit;
		hit = 1'b0;
		unique case (sens)
			SENS_TOGGLE:  hit = cur ^ prev;
			SENS_FALLING: hit = prev & ~cur;
			SENS_RISING:  hit = cur & ~prev;
			SENS_RSVD:    hit = 1'b0;
		endcase
		return hit;
	endfunction

	// Byte lane 0 merge used by the control and disable register writes
	function automatic logic [7:0] lane0(input logic [7:0] old,
		input logic [31:0] wdata, input logic [3:0] be);
		return be[0] ? wdata[7:0] : old;
	endfunction

	// Address match shared by the read mux and the write strobes
	function automatic logic addr_hit(input logic [4:0] addr,
		input logic [4:0] ofs);
		return addr == ofs;
	endfunction

	// Writable bits; control bit 3 and disable-one bits 7:6 stay zero
	localparam logic [31:0] CTRL_WMASK = 32'h000000f7;
	localparam logic [31:0] DIS1_WMASK = 32'h0000003f;

	// ****************************************
	// Register state
	// ****************************************
	csf_ctrl_t                  ctrl [NUM_CMP];
	logic                       clock_halve;
	logic [NUM_CMP-1:0]         event_flag;
	logic [7:0]                 input_disable_zero;
	logic [7:0]                 input_disable_one;

	// ****************************************
	// Synchronisers
	// ****************************************
	logic [NUM_CMP-1:0]         cmp_meta;
	logic [NUM_CMP-1:0]         cmp_sync;
	csf_pins_t                  pin_meta;
	csf_pins_t                  pin_sync;
	// Results and pin levels move with no regard to core_clk: two stages

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cmp_meta <= '0;
			cmp_sync <= '0;
			pin_meta <= '0;
			pin_sync <= '0;
		end
		else if (clk_en)
		begin
			cmp_meta <= cmp_result;
			cmp_sync <= cmp_meta;
			pin_meta <= pin_level;
			pin_sync <= pin_meta;
		end
	end

	// ****************************************
	// Comparator clock
	// ****************************************
	// The strobe stands for the falling edge of the comparator clock; a
	// strobe per cycle avoids a gated clock in the core domain.
	logic                       half_phase;
	wire logic next_strobe = clock_halve ? half_phase : 1'b1;

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			half_phase        <= 1'b0;
			cmp_sample_strobe <= 1'b0;
		end
		else if (clk_en)
		begin
			half_phase        <= clock_halve ? ~half_phase : 1'b0;
			cmp_sample_strobe <= next_strobe;
		end
	end

	// ****************************************
	// Sampling and edge detection
	// ****************************************
	logic [NUM_CMP-1:0]         cmp_sample;
	logic [NUM_CMP-1:0]         cmp_prev;
	logic [NUM_CMP-1:0]         cmp_event;

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cmp_sample <= '0;
			cmp_prev   <= '0;
		end
		else if (clk_en)
		begin
			if (cmp_sample_strobe)
				cmp_sample <= cmp_sync;
			cmp_prev <= cmp_sample;
		end
	end

	for (genvar i = 0; i < NUM_CMP; i++)
	begin : g_edge
		assign cmp_event[i] = edge_hit(ctrl[i].sensitivity,
			cmp_sample[i], cmp_prev[i]);
	end

	// ****************************************
	// Bus decode
	// ****************************************
	wire logic bus_req   = avs_read | avs_write;
	wire logic bus_done  = bus_req & ~avs_waitrequest;
	wire logic wr_done   = bus_done & avs_write;
	wire logic hit_ctrl0 = addr_hit(avs_address, OFS_CMP0_CONTROL);
	wire logic hit_ctrl1 = addr_hit(avs_address, OFS_CMP1_CONTROL);
	wire logic hit_ctrl2 = addr_hit(avs_address, OFS_CMP2_CONTROL);
	wire logic hit_sts   = addr_hit(avs_address, OFS_COMPARATOR_STATUS);
	wire logic hit_did0  = addr_hit(avs_address, OFS_INPUT_DISABLE_ZERO);
	wire logic hit_did1  = addr_hit(avs_address, OFS_INPUT_DISABLE_ONE);
	wire logic [NUM_CMP-1:0] wr_ctrl =
		{3{wr_done}} & {hit_ctrl2, hit_ctrl1, hit_ctrl0};
	wire logic wr_sts    = wr_done & hit_sts & avs_byteenable[0];

	wire logic [7:0] status_view = {clock_halve, event_flag, 1'b0,
		cmp_sample};

	logic [7:0]                 rd_byte;
	always_comb
	begin
		rd_byte = 8'h00;
		if (hit_ctrl0)
			rd_byte = ctrl[0];
		if (hit_ctrl1)
			rd_byte = ctrl[1];
		if (hit_ctrl2)
			rd_byte = ctrl[2];
		if (hit_sts)
			rd_byte = status_view;
		if (hit_did0)
			rd_byte = input_disable_zero;
		if (hit_did1)
			rd_byte = input_disable_one;
	end

	// ****************************************
	// Bus handshake
	// ****************************************
	// One wait cycle per access; unmapped reads return zero.
	// Read data latched in the wait cycle stands at the completing edge
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= '0;
		end
		else if (clk_en)
		begin
			avs_waitrequest <= ~(bus_req & avs_waitrequest);
			if (avs_read & avs_waitrequest)
				avs_readdata <= {24'h000000, rd_byte};
		end
	end

	// ****************************************
	// Control registers
	// ****************************************
	for (genvar i = 0; i < NUM_CMP; i++)
	begin : g_ctrl
		always_ff @(posedge core_clk or negedge rstn)
		begin
			if (!rstn)
				ctrl[i] <= RST_CONTROL;
			else if (clk_en && wr_ctrl[i])
				ctrl[i] <= lane0(ctrl[i], avs_writedata & CTRL_WMASK,
					avs_byteenable);
		end
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			clock_halve        <= RST_STATUS[STS_CLOCK_HALVE];
			input_disable_zero <= RST_DISABLE;
			input_disable_one  <= RST_DISABLE;
		end
		else if (clk_en)
		begin
			if (wr_sts)
				clock_halve <= avs_writedata[STS_CLOCK_HALVE];
			if (wr_done && hit_did0)
				input_disable_zero <= lane0(input_disable_zero,
					avs_writedata, avs_byteenable);
			if (wr_done && hit_did1)
				input_disable_one <= lane0(input_disable_one,
					avs_writedata & DIS1_WMASK, avs_byteenable);
		end
	end

	// ****************************************
	// Event flags
	// ****************************************
	logic [NUM_CMP-1:0]         ie_vec;
	for (genvar i = 0; i < NUM_CMP; i++)
	begin : g_ie
		assign ie_vec[i] = ctrl[i].irq_enable;
	end

	wire logic [NUM_CMP-1:0] flag_w1c = {NUM_CMP{wr_sts}} &
		avs_writedata[STS_FLAG_LO +: NUM_CMP];
	wire logic [NUM_CMP-1:0] flag_ack = irq_vector_taken & ie_vec;
	// Set is applied last so an event in the clearing cycle survives
	wire logic [NUM_CMP-1:0] next_flag =
		(event_flag & ~(flag_w1c | flag_ack)) | cmp_event;

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			event_flag <= RST_STATUS[STS_FLAG_LO +: NUM_CMP];
		else if (clk_en)
			event_flag <= next_flag;
	end

	// ****************************************
	// Outputs to comparators and consumers
	// ****************************************
	logic [NUM_CMP-1:0]         en_vec;
	for (genvar i = 0; i < NUM_CMP; i++)
	begin : g_en
		assign en_vec[i] = ctrl[i].enable;
	end

	// Reserved select codes are passed through; the mux treats them as off
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cmp_enable      <= '0;
			cmp2_neg_select <= SEL_REF_DIV_6P40;
			irq_request     <= '0;
			conv_trigger    <= '0;
		end
		else if (clk_en)
		begin
			cmp_enable      <= en_vec;
			cmp2_neg_select <= ctrl[2].neg_select;
			irq_request     <= next_flag & ie_vec;
			conv_trigger    <= next_flag;
		end
	end

	// ****************************************
	// Pin input buffers
	// ****************************************
	// Gating with the next disable value makes off and read flip together
	csf_pins_t                  next_off;
	assign next_off.neg_pin  = input_disable_zero[DZ_NEG_PIN];
	assign next_off.cmp2_pin = input_disable_zero[DZ_CMP2_PIN];
	assign next_off.cmp0_pin = input_disable_one[DO_CMP0_PIN];
	assign next_off.cmp1_pin = input_disable_one[DO_CMP1_PIN];

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pin_buffer_off <= '0;
			pin_read       <= '0;
		end
		else if (clk_en)
		begin
			pin_buffer_off <= next_off;
			pin_read       <= pin_sync & ~next_off;
		end
	end

endmodule

// ### core/csf_pkg.sv
// Package for the comparator status and flag block: offsets, fields, types.
// Assumes a 32-bit Avalon-MM register bus and three clocked comparators.
package csf_pkg;

	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [4:0] OFS_CMP0_CONTROL     = 5'h00;
	localparam logic [4:0] OFS_CMP1_CONTROL     = 5'h04;
	localparam logic [4:0] OFS_CMP2_CONTROL     = 5'h08;
	localparam logic [4:0] OFS_COMPARATOR_STATUS = 5'h0c;
	localparam logic [4:0] OFS_INPUT_DISABLE_ZERO = 5'h10;
	localparam logic [4:0] OFS_INPUT_DISABLE_ONE  = 5'h14;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [7:0] RST_STATUS  = 8'h00;
	localparam logic [7:0] RST_DISABLE = 8'h00;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int STS_CLOCK_HALVE = 7;
	localparam int STS_FLAG_LO     = 4;
	localparam int STS_MIRROR_LO   = 0;
	localparam int DZ_NEG_PIN      = 3;
	localparam int DZ_CMP2_PIN     = 2;
	localparam int DO_CMP0_PIN     = 5;
	localparam int DO_CMP1_PIN     = 2;

	// Negative input select codes of comparator 2
	localparam logic [2:0] SEL_REF_DIV_6P40 = 3'h0;
	localparam logic [2:0] SEL_REF_DIV_3P20 = 3'h1;
	localparam logic [2:0] SEL_REF_DIV_2P13 = 3'h2;
	localparam logic [2:0] SEL_REF_DIV_1P60 = 3'h3;
	localparam logic [2:0] SEL_NEG_PIN      = 3'h4;
	localparam logic [2:0] SEL_DAC_OUT      = 3'h5;

	// Edge sensitivity codes
	typedef enum logic [1:0] {
		SENS_TOGGLE  = 2'h0,
		SENS_RSVD    = 2'h1,
		SENS_FALLING = 2'h2,
		SENS_RISING  = 2'h3
	} csf_sens_t;

	// Per-comparator control byte
	typedef struct packed {
		logic      enable;
		logic      irq_enable;
		csf_sens_t sensitivity;
		logic      unused;
		logic [2:0] neg_select;
	} csf_ctrl_t;

	// Pin group: neg pin, cmp2 pin, cmp0 pos, cmp1 pos
	typedef struct packed {
		logic neg_pin;
		logic cmp2_pin;
		logic cmp0_pin;
		logic cmp1_pin;
	} csf_pins_t;

endpackage

// ### verif/csf_chk.sv
// Checker for the comparator status block, bound to its top module.
// Assumes one clock domain and async active-low reset; clk_en only drops
// while the bus is idle and the comparator clock runs at full rate.
`timescale 1ns/1ps

module csf_chk
	import csf_pkg::*;
#(
	parameter int NUM_CMP = 3
)
(
	// Clock and reset
	input wire logic               core_clk,
	input wire logic               rstn,
	input wire logic               clk_en,
	// Bus
	input wire logic               avs_read,
	input wire logic               avs_write,
	input wire logic [31:0]        avs_readdata,
	input wire logic               avs_waitrequest,
	// Comparators and events
	input wire logic [NUM_CMP-1:0] cmp_result,
	input wire logic [NUM_CMP-1:0] cmp_enable,
	input wire logic [2:0]         cmp2_neg_select,
	input wire logic               cmp_sample_strobe,
	input wire logic [NUM_CMP-1:0] irq_vector_taken,
	input wire logic [NUM_CMP-1:0] irq_request,
	input wire logic [NUM_CMP-1:0] conv_trigger,
	// Pins
	input wire csf_pins_t          pin_buffer_off,
	input wire csf_pins_t          pin_read
);
	// ****
	// Properties
	// ****
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	property p_irq;
		(irq_request & ~conv_trigger) == '0;
	endproperty
	a_irq: assert property (p_irq) else $error("irq without flag");
	property p_gate;
		(pin_read & pin_buffer_off) == 4'h0;
	endproperty
	a_gate: assert property (p_gate) else $error("pin read leak");
	property p_resp;
		(avs_read || avs_write) && avs_waitrequest |=>
			!avs_waitrequest ##1 avs_waitrequest;
	endproperty
	a_resp: assert property (p_resp) else $error("bus answer");
	property p_strobe;
		!cmp_sample_strobe |=> cmp_sample_strobe;
	endproperty
	a_strobe: assert property (p_strobe) else $error("strobe gap");
	// Eight quiet, running cycles leave no edge in flight through the sync
	// stages; a frozen core holds its edge until clk_en returns
	property p_noevt;
		($stable(cmp_result) && clk_en) [*8] |->
			(conv_trigger & ~$past(conv_trigger)) == '0;
	endproperty
	a_noevt: assert property (p_noevt) else $error("flag no edge");
	property p_clr;
		(~conv_trigger & $past(conv_trigger)) != '0 |->
			$past(avs_write) || $past(|irq_vector_taken);
	endproperty
	a_clr: assert property (p_clr) else $error("flag dropped");
	// Control outputs follow the register one edge after the write lands
	property p_ctrl;
		!$stable({cmp_enable, cmp2_neg_select}) |->
			$past(avs_write && !avs_waitrequest, 2);
	endproperty
	a_ctrl: assert property (p_ctrl) else $error("ctrl moved");
	property p_hi;
		avs_readdata[31:8] == 24'h0;
	endproperty
	a_hi: assert property (p_hi) else $error("readdata high");
	c_flag: cover property ((conv_trigger & ~$past(conv_trigger)) != '0);
	c_half: cover property (!cmp_sample_strobe);
	c_vec: cover property ((irq_vector_taken & irq_request) != '0);
endmodule

bind csf_comparator_status csf_chk #(.NUM_CMP(NUM_CMP)) csf_chk_i (
	.core_clk(core_clk), .rstn(rstn), .clk_en(clk_en),
	.avs_read(avs_read),
	.avs_write(avs_write), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .cmp_result(cmp_result),
	.cmp_enable(cmp_enable), .cmp2_neg_select(cmp2_neg_select),
	.cmp_sample_strobe(cmp_sample_strobe),
	.irq_vector_taken(irq_vector_taken), .irq_request(irq_request),
	.conv_trigger(conv_trigger), .pin_buffer_off(pin_buffer_off),
	.pin_read(pin_read)
);

// ### verif/csf_analog_model.sv
// Behavioural model of the three comparator cores.
// Assumes the bench sets each core's analog decision level.
`timescale 1ns/1ps

module csf_analog_model
	import csf_pkg::*;
#(
	parameter int NUM_CMP = 3
)
(
	// Analog decision and core enable
	input  wire logic [NUM_CMP-1:0] level,
	input  wire logic [NUM_CMP-1:0] cmp_enable,
	// Core outputs
	output logic      [NUM_CMP-1:0] cmp_result
);
	// A disabled core holds low, so enabling it can look like an edge
	assign cmp_result = level & cmp_enable;
endmodule

// ### verif/comparator_status_flags_tb_top.sv
// Self-checking bench for the comparator status block.
// Assumes package, design, checker and core model compiled first.
`timescale 1ns/1ps

module comparator_status_flags_tb_top
	import csf_pkg::*;
;
	logic        core_clk;
	logic        rstn;
	logic        clk_en;
	logic        avs_read;
	logic        avs_write;
	logic [4:0]  avs_address;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [2:0]  level;
	logic [2:0]  cmp_result;
	logic [2:0]  cmp_enable;
	logic [2:0]  neg_sel;
	logic        strobe;
	logic [2:0]  vec;
	logic [2:0]  irq;
	logic [2:0]  trig;
	csf_pins_t   pin_level;
	csf_pins_t   pin_off;
	csf_pins_t   pin_read;
	logic [7:0]  q;
	int          failures;
	int          checked;

	csf_comparator_status csf_comparator_status_i (
		.core_clk(core_clk), .rstn(rstn), .clk_en(clk_en),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'h1), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .cmp_result(cmp_result),
		.cmp_enable(cmp_enable), .cmp2_neg_select(neg_sel),
		.cmp_sample_strobe(strobe), .irq_vector_taken(vec),
		.irq_request(irq), .conv_trigger(trig), .pin_level(pin_level),
		.pin_buffer_off(pin_off), .pin_read(pin_read)
	);
	csf_analog_model csf_analog_model_i (
		.level(level), .cmp_enable(cmp_enable), .cmp_result(cmp_result)
	);

	initial
	begin
		core_clk = 1'b0;
		forever
			#12.5 core_clk = ~core_clk;
	end

	// ****
	// Shared tasks
	// ****
	task automatic end_sim(input bit to);
		if (to)
			failures++;
		$display("checks %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			failures++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// One edge first, so a release never meets a new request in one step
	task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_write <= wr;
		avs_read <= !wr;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 50);
		if (avs_waitrequest !== 1'b0)
			end_sim(1'b1);
		q = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	// ****
	// Scenarios
	// ****
	task automatic s_reset;
		for (int i = 0; i < 7; i++)
		begin
			bus(1'b0, 5'(i * 4), 8'h00);
			chk("reset value", 32'h0, q);
		end
	endtask
	task automatic s_select;
		for (int c = 0; c < 8; c++)
		begin
			bus(1'b1, OFS_CMP2_CONTROL, 8'h88 | 8'(c));
			bus(1'b0, OFS_CMP2_CONTROL, 8'h00);
			chk("cmp2 control", 32'h80 | c, q);
			chk("neg select", c, neg_sel);
		end
		bus(1'b1, OFS_CMP2_CONTROL, 8'h00);
	endtask
	task automatic s_sens;
		int ef;
		for (int i = 0; i < 3; i++)
			for (int s = 0; s < 4; s++)
			begin
				bus(1'b1, 5'(i * 4), {2'b11, 2'(s), 4'h0});
				level[i] <= 1'b1;
				cyc(10);
				ef = (s == 0 || s == 3);
				chk("rise trigger", ef, trig[i]);
				chk("rise irq", ef, irq[i]);
				bus(1'b0, OFS_COMPARATOR_STATUS, 8'h00);
				chk("status", (ef << (4 + i)) | (1 << i), q);
				bus(1'b1, OFS_COMPARATOR_STATUS, 8'h70);
				level[i] <= 1'b0;
				cyc(10);
				ef = (s == 0 || s == 2);
				chk("fall trigger", ef, trig[i]);
				bus(1'b1, OFS_COMPARATOR_STATUS, 8'h70);
				bus(1'b0, OFS_COMPARATOR_STATUS, 8'h00);
				chk("cleared", 32'h0, q);
			end
	endtask
	task automatic s_vector;
		for (int k = 0; k < 2; k++)
		begin
			bus(1'b1, OFS_CMP0_CONTROL, k ? 8'hb0 : 8'hf0);
			level[0] <= 1'b1;
			cyc(10);
			chk("irq level", !k, irq[0]);
			vec[0] <= 1'b1;
			cyc(1);
			vec[0] <= 1'b0;
			cyc(2);
			chk("vector clear", k, trig[0]);
			bus(1'b1, OFS_COMPARATOR_STATUS, 8'h70);
			level[0] <= 1'b0;
			cyc(10);
		end
	endtask
	task automatic s_halve;
		int n;
		for (int h = 0; h < 2; h++)
		begin
			bus(1'b1, OFS_COMPARATOR_STATUS, {h[0], 7'h0});
			cyc(2);
			n = 0;
			repeat (20)
			begin
				@(posedge core_clk);
				if (strobe === 1'b1)
					n++;
			end
			chk("strobes", h ? 10 : 20, n);
			bus(1'b0, OFS_COMPARATOR_STATUS, 8'h00);
			chk("halve bit", h << 7, q);
		end
		bus(1'b1, OFS_COMPARATOR_STATUS, 8'h00);
	endtask
	// Freeze with an edge pending, then an edge that meets a flag clear
	task automatic s_corner;
		bus(1'b1, OFS_CMP1_CONTROL, 8'hc0);
		clk_en <= 1'b0;
		level[1] <= 1'b1;
		cyc(10);
		chk("frozen flag", 32'h0, trig[1]);
		clk_en <= 1'b1;
		cyc(10);
		chk("thawed flag", 32'h1, trig[1]);
		level[1] <= 1'b0;
		cyc(1);
		bus(1'b1, OFS_COMPARATOR_STATUS, 8'h70);
		cyc(2);
		chk("set beats clear", 32'h1, trig[1]);
		bus(1'b1, OFS_COMPARATOR_STATUS, 8'h70);
		cyc(2);
		chk("flag cleared", 32'h0, trig[1]);
	endtask
	task automatic s_pins;
		pin_level <= 4'hf;
		bus(1'b1, OFS_INPUT_DISABLE_ZERO, 8'h0c);
		cyc(5);
		chk("off zero", 32'hc, pin_off);
		chk("read zero", 32'h3, pin_read);
		bus(1'b1, OFS_INPUT_DISABLE_ZERO, 8'h00);
		bus(1'b1, OFS_INPUT_DISABLE_ONE, 8'hff);
		cyc(5);
		chk("off one", 32'h3, pin_off);
		chk("read one", 32'hc, pin_read);
		bus(1'b0, OFS_INPUT_DISABLE_ONE, 8'h00);
		chk("disable one", 32'h3f, q);
		bus(1'b1, OFS_INPUT_DISABLE_ONE, 8'h00);
		cyc(5);
		chk("read open", 32'hf, pin_read);
	endtask

	initial
	begin
		rstn = 1'b0;
		clk_en = 1'b1;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 5'h00;
		avs_writedata = 32'h0;
		level = 3'h0;
		vec = 3'h0;
		pin_level = 4'h0;
		failures = 0;
		checked = 0;
		repeat (6) @(posedge core_clk);
		rstn <= 1'b1;
		s_reset;
		s_select;
		s_sens;
		s_vector;
		s_halve;
		s_corner;
		s_pins;
		end_sim(1'b0);
	end
endmodule
